// ---- src/pefc_pkg.sv ----
// Shared constants and carrier types for the PLL event flag combiner.
// Assumes a 32-bit APB slave at 40 MHz with byte addresses of four times the register index.
package pefc_pkg;

  localparam int PEFC_ADDR_W = 8;
  localparam int PEFC_DATA_W = 32;
  localparam int PEFC_NSRC = 8;
  localparam int PEFC_NSLEW = 4;

  // Register indices; the byte address is four times the index.
  localparam logic [PEFC_ADDR_W-1:0] PEFC_IDX_LIVE = 8'h0D;
  localparam logic [PEFC_ADDR_W-1:0] PEFC_IDX_MASK = 8'h0E;
  localparam logic [PEFC_ADDR_W-1:0] PEFC_IDX_POL = 8'h0F;
  localparam logic [PEFC_ADDR_W-1:0] PEFC_IDX_FLAG = 8'h10;
  localparam logic [PEFC_ADDR_W-1:0] PEFC_IDX_CTL = 8'h11;
  localparam logic [PEFC_ADDR_W-1:0] PEFC_IDX_SLEW = 8'h12;
  localparam logic [PEFC_ADDR_W-1:0] PEFC_IDX_DRV = 8'h13;

  // Source bit positions inside the flag, mask, polarity and live view registers.
  localparam int PEFC_SRC_P1_LOL = 7;
  localparam int PEFC_SRC_P1_LOS = 6;
  localparam int PEFC_SRC_P2_LOL = 4;
  localparam int PEFC_SRC_P2_LOS = 3;

  // Control, slew status and drive configuration field positions.
  localparam int PEFC_CTL_EN_BIT = 0;
  localparam int PEFC_CTL_AND_BIT = 1;
  localparam int PEFC_SLEW_LSB = 4;
  localparam int PEFC_DRV_OD0_BIT = 0;
  localparam int PEFC_DRV_OD1_BIT = 1;
  localparam int PEFC_DRV_RSV_LSB = 2;
  localparam int PEFC_DRV_SL0_BIT = 4;
  localparam int PEFC_DRV_SL1_BIT = 5;

  // Reset values.
  localparam logic [7:0] PEFC_RST_FLAG = 8'h00;
  localparam logic [7:0] PEFC_RST_MASK = 8'h00;
  localparam logic [7:0] PEFC_RST_POL = 8'h00;
  localparam logic [1:0] PEFC_RST_CTL = 2'h0;
  localparam logic [5:0] PEFC_RST_DRV = 6'h00;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [PEFC_ADDR_W-1:0] paddr;
    logic [PEFC_DATA_W-1:0] pwdata;
  } pefc_apb_req_t;

  typedef struct packed {
    logic pready;
    logic [PEFC_DATA_W-1:0] prdata;
    logic pslverr;
  } pefc_apb_rsp_t;

  // Packed so that the first member lands on bit 7.
  typedef struct packed {
    logic pll1_lock_loss_src;
    logic pll1_input_loss_src;
    logic pll1_vco_calib_src;
    logic pll2_lock_loss_src;
    logic pll2_input_loss_src;
    logic pll2_vco_calib_src;
    logic pll1_switchback_src;
    logic pll2_switchback_src;
  } pefc_src_t;

  typedef struct packed {
    logic sec_ref_rise_ok;
    logic sec_ref_fall_ok;
    logic pri_ref_rise_ok;
    logic pri_ref_fall_ok;
  } pefc_slew_t;

  typedef struct packed {
    logic out;
    logic oe;
  } pefc_pin_t;

endpackage

// ---- src/pefc_edge_cell.sv ----
// One sticky event flag with its own edge detector.
// Assumes a source already synchronised to pclk.
`timescale 1ns/1ps
module pefc_edge_cell (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Source and controls
  input wire logic src,
  input wire logic pol,
  input wire logic capture_en,
  input wire logic clear_req,
  // Results
  output logic flag,
  output logic edge_hit
);

  logic prev_reg;
  logic prev_next;
  logic flag_reg;
  logic flag_next;

  always_comb begin
    prev_next = src;
    edge_hit = pol ? (src & ~prev_reg) : (~src & prev_reg); // R13
    // A capture in the same cycle as a clear keeps the flag set.
    flag_next = (edge_hit & capture_en) | (flag_reg & ~clear_req); // R01 R03 R11
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= 1'b0;
      flag_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
      flag_reg <= flag_next;
    end
  end

  assign flag = flag_reg;

  sequence s_rise;
    !src ##1 (src && pol && capture_en);
  endsequence

  sequence s_fall;
    src ##1 (!src && !pol && capture_en);
  endsequence

  property p_rise_sets;
    @(posedge pclk) disable iff (!presetn) s_rise |=> flag_reg;
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("Rising edge did not set flag."); // R13

  property p_fall_sets;
    @(posedge pclk) disable iff (!presetn) s_fall |=> flag_reg;
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("Falling edge did not set flag."); // R01

endmodule

// ---- src/pefc_top.sv ----
// PLL event flag combiner: sticky flags, masks, combine logic and status pin drive.
// Assumes an APB master on pclk and event sources and slew indicators from other domains.
//
// What this block does
// R01: Eight sticky flags, bits 7..0, set by a source edge of programmed polarity.
// R02: Writing zero to a flag bit clears it; software acknowledges this way.
// R03: Flags capture edges only while the global enable is one.
// R04: Control bit 1 high: interrupt only when all unmasked flags are active.
// R05: Control bit 1 low, its reset value: any unmasked flag raises the interrupt.
// R06: Control bit 0 is global enable, resets low, silences both status pins.
// R07: A live view shows the present level of every source, with each lock-loss bit hidden under input loss as in R15.
// R08: Four read-only slew valid bits in 7..4, low four bits reserved.
// R09: Drive bits 1 and 0 select open-drain on status pins one and zero.
// R10: Drive bits 5 and 4 select spike-limited drive on pins one and zero.
// R11: Writing one leaves a flag; a coinciding edge beats the clear.
// R12: Combination uses masked flags; masked sources are ignored in AND and OR.
// R13: Polarity bit one detects rising edges, zero falling; all reset to zero.
// R14: A mask bit of one keeps its source off the interrupt; masks reset zero.
// R15: Input loss on a PLL hides that PLL's lock-loss source.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module pefc_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire pefc_pkg::pefc_apb_req_t apb_req,
  output pefc_pkg::pefc_apb_rsp_t apb_rsp,
  // Event sources and slew indicators, asynchronous
  input wire pefc_pkg::pefc_src_t src_in,
  input wire pefc_pkg::pefc_slew_t slew_in,
  // Status pins
  output pefc_pkg::pefc_pin_t status_pin_zero,
  output pefc_pkg::pefc_pin_t status_pin_one,
  // Pad drive strength selects
  output logic stat_pin0_spike_limit,
  output logic stat_pin1_spike_limit
);
  import pefc_pkg::*;

  localparam int SYNC_W = PEFC_NSRC + PEFC_NSLEW;

  // Synchronisers.
  logic [SYNC_W-1:0] meta_reg;
  logic [SYNC_W-1:0] sync_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= {src_in, slew_in};
      sync_reg <= meta_reg;
    end
  end

  logic [PEFC_NSRC-1:0] src_raw;
  logic [PEFC_NSLEW-1:0] slew_sync;
  logic [PEFC_NSRC-1:0] irq_source_live_view;

  always_comb begin
    src_raw = sync_reg[SYNC_W-1:PEFC_NSLEW];
    slew_sync = sync_reg[PEFC_NSLEW-1:0];
    irq_source_live_view = src_raw; // R07
    // Input loss explains the lock loss, so only the input-loss source is raised.
    irq_source_live_view[PEFC_SRC_P1_LOL] = src_raw[PEFC_SRC_P1_LOL] &
                                            ~src_raw[PEFC_SRC_P1_LOS]; // R15
    irq_source_live_view[PEFC_SRC_P2_LOL] = src_raw[PEFC_SRC_P2_LOL] &
                                            ~src_raw[PEFC_SRC_P2_LOS]; // R15
  end

  // Register state.
  logic [7:0] int_mask_reg;
  logic [7:0] int_mask_next;
  logic [7:0] edge_polarity_reg;
  logic [7:0] edge_polarity_next;
  logic [1:0] irq_control_reg;
  logic [1:0] irq_control_next;
  logic [5:0] status_pin_drive_config_reg;
  logic [5:0] status_pin_drive_config_next;
  logic [PEFC_DATA_W-1:0] prdata_reg;
  logic [PEFC_DATA_W-1:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;

  logic [PEFC_NSRC-1:0] event_flag_sticky;
  logic [PEFC_NSRC-1:0] edge_hit;
  logic [PEFC_NSRC-1:0] flag_clear;
  logic ctl_en;
  logic ctl_and;
  logic setup;
  logic wr_take;
  logic wr_flag;
  logic hit;
  logic [PEFC_DATA_W-1:0] rd_data;
  logic [PEFC_ADDR_W-1:0] a;

  assign ctl_en = irq_control_reg[PEFC_CTL_EN_BIT];
  assign ctl_and = irq_control_reg[PEFC_CTL_AND_BIT];
  assign setup = apb_req.psel & ~apb_req.penable;
  assign wr_take = apb_req.psel & apb_req.penable & pready_reg & apb_req.pwrite;
  assign a = apb_req.paddr;
  assign wr_flag = wr_take & (a == PEFC_ADDR_W'(PEFC_IDX_FLAG * 4));
  assign flag_clear = wr_flag ? ~apb_req.pwdata[PEFC_NSRC-1:0] : '0; // R02 R11

  // Address decode for reads and for the error answer.
  always_comb begin
    rd_data = '0;
    hit = 1'b1;
    if (a == PEFC_ADDR_W'(PEFC_IDX_LIVE * 4)) begin
      rd_data[PEFC_NSRC-1:0] = irq_source_live_view; // R07
    end else if (a == PEFC_ADDR_W'(PEFC_IDX_MASK * 4)) begin
      rd_data[7:0] = int_mask_reg;
    end else if (a == PEFC_ADDR_W'(PEFC_IDX_POL * 4)) begin
      rd_data[7:0] = edge_polarity_reg;
    end else if (a == PEFC_ADDR_W'(PEFC_IDX_FLAG * 4)) begin
      rd_data[PEFC_NSRC-1:0] = event_flag_sticky;
    end else if (a == PEFC_ADDR_W'(PEFC_IDX_CTL * 4)) begin
      rd_data[1:0] = irq_control_reg;
    end else if (a == PEFC_ADDR_W'(PEFC_IDX_SLEW * 4)) begin
      rd_data[PEFC_SLEW_LSB +: PEFC_NSLEW] = slew_sync; // R08
    end else if (a == PEFC_ADDR_W'(PEFC_IDX_DRV * 4)) begin
      rd_data[5:0] = status_pin_drive_config_reg;
    end else begin
      hit = 1'b0;
    end
  end

  // Every transfer completes in the first access cycle; read data is captured at setup.
  always_comb begin
    pready_next = setup;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    if (setup) begin
      prdata_next = apb_req.pwrite ? '0 : rd_data;
      pslverr_next = ~hit;
    end
  end

  always_comb begin
    int_mask_next = int_mask_reg;
    edge_polarity_next = edge_polarity_reg;
    irq_control_next = irq_control_reg;
    status_pin_drive_config_next = status_pin_drive_config_reg;
    if (wr_take) begin
      if (a == PEFC_ADDR_W'(PEFC_IDX_MASK * 4)) begin
        int_mask_next = apb_req.pwdata[7:0]; // R14
      end else if (a == PEFC_ADDR_W'(PEFC_IDX_POL * 4)) begin
        edge_polarity_next = apb_req.pwdata[7:0]; // R13
      end else if (a == PEFC_ADDR_W'(PEFC_IDX_CTL * 4)) begin
        irq_control_next = apb_req.pwdata[1:0]; // R04 R06
      end else if (a == PEFC_ADDR_W'(PEFC_IDX_DRV * 4)) begin
        status_pin_drive_config_next = apb_req.pwdata[5:0]; // R09 R10
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_mask_reg <= PEFC_RST_MASK;
      edge_polarity_reg <= PEFC_RST_POL;
      irq_control_reg <= PEFC_RST_CTL;
      status_pin_drive_config_reg <= PEFC_RST_DRV;
      prdata_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      int_mask_reg <= int_mask_next;
      edge_polarity_reg <= edge_polarity_next;
      irq_control_reg <= irq_control_next;
      status_pin_drive_config_reg <= status_pin_drive_config_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign apb_rsp.pready = pready_reg;
  assign apb_rsp.prdata = prdata_reg;
  assign apb_rsp.pslverr = pslverr_reg;

  // Sticky flags, one cell per source.
  for (genvar i = 0; i < PEFC_NSRC; i++) begin : g_cell
    pefc_edge_cell u_cell (
      .pclk(pclk),
      .presetn(presetn),
      .src(irq_source_live_view[i]),
      .pol(edge_polarity_reg[i]),
      .capture_en(ctl_en),
      .clear_req(flag_clear[i]),
      .flag(event_flag_sticky[i]),
      .edge_hit(edge_hit[i])
    );
  end

  // Combination. With every source masked the AND form would be vacuous, so it stays low.
  logic irq_reg;
  logic irq_next;
  logic [PEFC_NSRC-1:0] live_flags;
  logic od0;
  logic od1;
  pefc_pin_t pin0_reg;
  pefc_pin_t pin0_next;
  pefc_pin_t pin1_reg;
  pefc_pin_t pin1_next;
  logic sl0_reg;
  logic sl1_reg;

  assign od0 = status_pin_drive_config_reg[PEFC_DRV_OD0_BIT];
  assign od1 = status_pin_drive_config_reg[PEFC_DRV_OD1_BIT];

  always_comb begin
    live_flags = event_flag_sticky & ~int_mask_reg; // R12 R14
    if (!ctl_en) begin
      irq_next = 1'b0; // R06
    end else if (ctl_and) begin
      irq_next = (&(event_flag_sticky | int_mask_reg)) & ~(&int_mask_reg); // R04 R12
    end else begin
      irq_next = |live_flags; // R05
    end
    // Open drain can only pull low, so it signals by driving and is released otherwise.
    pin0_next.out = od0 ? 1'b0 : irq_next; // R09
    pin0_next.oe = od0 ? irq_next : 1'b1; // R09
    pin1_next.out = od1 ? 1'b0 : irq_next; // R09
    pin1_next.oe = od1 ? irq_next : 1'b1; // R09
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
      pin0_reg <= '{out: 1'b0, oe: 1'b1};
      pin1_reg <= '{out: 1'b0, oe: 1'b1};
      sl0_reg <= 1'b0;
      sl1_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
      pin0_reg <= pin0_next;
      pin1_reg <= pin1_next;
      sl0_reg <= status_pin_drive_config_next[PEFC_DRV_SL0_BIT]; // R10
      sl1_reg <= status_pin_drive_config_next[PEFC_DRV_SL1_BIT]; // R10
    end
  end

  assign status_pin_zero = pin0_reg;
  assign status_pin_one = pin1_reg;
  assign stat_pin0_spike_limit = sl0_reg;
  assign stat_pin1_spike_limit = sl1_reg;

  // Checks.
  property p_capture;
    @(posedge pclk) disable iff (!presetn)
      ctl_en |=> ((event_flag_sticky & $past(edge_hit)) == $past(edge_hit));
  endproperty
  a_capture: assert property (p_capture) else $error("Enabled edge did not set its flag."); // R01

  property p_no_capture;
    @(posedge pclk) disable iff (!presetn)
      !ctl_en |=> ((event_flag_sticky & ~$past(event_flag_sticky)) == '0);
  endproperty
  a_no_capture: assert property (p_no_capture) else $error("Flag set while disabled."); // R03

  property p_clear;
    @(posedge pclk) disable iff (!presetn)
      wr_flag |=> ((event_flag_sticky & ~$past(apb_req.pwdata[7:0]) &
                    ~($past(edge_hit) & {8{$past(ctl_en)}})) == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("Zero write did not clear flag."); // R02

  property p_set_wins;
    @(posedge pclk) disable iff (!presetn)
      wr_flag |=> ((event_flag_sticky & $past(event_flag_sticky | (edge_hit & {8{ctl_en}})) &
                    $past(apb_req.pwdata[7:0])) ==
                   $past((event_flag_sticky | (edge_hit & {8{ctl_en}})) & apb_req.pwdata[7:0]))
               ##0 ((event_flag_sticky & $past(edge_hit & {8{ctl_en}})) ==
                    $past(edge_hit & {8{ctl_en}}));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("Flag lost on write."); // R11

  property p_and_mode;
    @(posedge pclk) disable iff (!presetn)
      (ctl_en && ctl_and && !(&int_mask_reg)) |=>
        (irq_reg == (&$past(event_flag_sticky | int_mask_reg)))
        ##1 (status_pin_zero.out || od0) == (irq_reg || od0);
  endproperty
  a_and_mode: assert property (p_and_mode) else $error("AND combination wrong."); // R04

  property p_or_mode;
    @(posedge pclk) disable iff (!presetn)
      (ctl_en && !ctl_and) |=> (irq_reg == (|$past(live_flags)));
  endproperty
  a_or_mode: assert property (p_or_mode) else $error("OR combination wrong."); // R05

  sequence s_off;
    !ctl_en ##1 !ctl_en;
  endsequence

  property p_silent;
    @(posedge pclk) disable iff (!presetn)
      s_off |=> (!status_pin_zero.out && !status_pin_one.out &&
                 (!status_pin_zero.oe || !$past(od0)) && (!status_pin_one.oe || !$past(od1)));
  endproperty
  a_silent: assert property (p_silent) else $error("Pin signalled while disabled."); // R06

  property p_masked;
    @(posedge pclk) disable iff (!presetn)
      (&int_mask_reg) |=> !irq_reg;
  endproperty
  a_masked: assert property (p_masked) else $error("Fully masked but interrupt high."); // R14

  property p_live_read;
    @(posedge pclk) disable iff (!presetn)
      (setup && !apb_req.pwrite && a == PEFC_ADDR_W'(PEFC_IDX_LIVE * 4)) |=>
        (apb_rsp.prdata == {24'h000000, $past(irq_source_live_view)}) && apb_rsp.pready;
  endproperty
  a_live_read: assert property (p_live_read) else $error("Live view read wrong."); // R07

  property p_slew_read;
    @(posedge pclk) disable iff (!presetn)
      (setup && !apb_req.pwrite && a == PEFC_ADDR_W'(PEFC_IDX_SLEW * 4)) |=>
        (apb_rsp.prdata == {24'h000000, $past(slew_sync), 4'h0});
  endproperty
  a_slew_read: assert property (p_slew_read) else $error("Slew status read wrong."); // R08

  property p_los_first;
    @(posedge pclk) disable iff (!presetn)
      src_raw[PEFC_SRC_P1_LOS] |-> !irq_source_live_view[PEFC_SRC_P1_LOL];
  endproperty
  a_los_first: assert property (p_los_first) else $error("Lock loss shown with input loss."); // R15

  property p_open_drain;
    @(posedge pclk) disable iff (!presetn)
      od1 |=> !status_pin_one.out;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("Open-drain pin drove high."); // R09

endmodule

// ---- testbench/pefc_host_model.sv ----
// Host side of the status pins: resolves each pin to the level that the host samples.
// Assumes a board pull-up on both status lines, so a released open-drain line reads high.
`timescale 1ns/1ps
module pefc_host_model (
  // Pins from the block
  input wire pefc_pkg::pefc_pin_t pin0,
  input wire pefc_pkg::pefc_pin_t pin1,
  // Levels seen by the host
  output logic wire0,
  output logic wire1
);
  import pefc_pkg::*;

  // A released line must not keep its last value, so the pull-up decides it.
  assign wire0 = pin0.oe ? pin0.out : 1'b1;
  assign wire1 = pin1.oe ? pin1.out : 1'b1;
endmodule

// ---- testbench/pefc_top_bench.sv ----
// Self-checking bench for the PLL event flag combiner, with scenario tasks over APB.
// Assumes zero-wait-state APB answers, though every wait is bounded rather than counted.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module pefc_top_bench;
  import pefc_pkg::*;

  localparam logic [7:0] A_LIVE = PEFC_IDX_LIVE << 2;
  localparam logic [7:0] A_MASK = PEFC_IDX_MASK << 2;
  localparam logic [7:0] A_POL = PEFC_IDX_POL << 2;
  localparam logic [7:0] A_FLAG = PEFC_IDX_FLAG << 2;
  localparam logic [7:0] A_CTL = PEFC_IDX_CTL << 2;
  localparam logic [7:0] A_SLEW = PEFC_IDX_SLEW << 2;
  localparam logic [7:0] A_DRV = PEFC_IDX_DRV << 2;

  logic pclk;
  logic presetn;
  pefc_apb_req_t req;
  pefc_apb_rsp_t rsp;
  pefc_src_t src;
  pefc_slew_t slew;
  pefc_pin_t pin0;
  pefc_pin_t pin1;
  logic sl0;
  logic sl1;
  logic wire0;
  logic wire1;
  logic [31:0] rdat;
  logic errb;
  int n_fail;
  int samples_checked;

  pefc_top DUT (
    .pclk(pclk),
    .presetn(presetn),
    .apb_req(req),
    .apb_rsp(rsp),
    .src_in(src),
    .slew_in(slew),
    .status_pin_zero(pin0),
    .status_pin_one(pin1),
    .stat_pin0_spike_limit(sl0),
    .stat_pin1_spike_limit(sl1)
  );

  pefc_host_model host (
    .pin0(pin0),
    .pin1(pin1),
    .wire0(wire0),
    .wire1(wire1)
  );

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (rsp.pready === 1'b1) break;
    end
    if (i == 16) begin
      n_fail++;
      complete_run();
    end
    rdat = rsp.prdata;
    errb = rsp.pslverr;
    req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h00000000);
  endtask

  // Source changes cross a two-stage synchroniser, so settle before looking.
  task automatic drive_src(input logic [7:0] v);
    @(posedge pclk);
    src <= v;
    repeat (6) @(posedge pclk);
  endtask

  task automatic settle();
    repeat (3) @(posedge pclk);
  endtask

  task automatic t_reset_values();
    logic [7:0] regs [5];
    regs = '{A_MASK, A_POL, A_FLAG, A_CTL, A_DRV};
    foreach (regs[i]) begin
      rd(regs[i]);
      `CHK(rdat, 32'h00000000)
    end
    `CHK(pin0, 2'h1)
    `CHK({sl1, sl0}, 2'h0)
  endtask

  task automatic t_disabled_capture();
    drive_src(8'hD8);
    rd(A_LIVE);
    `CHK(rdat, 32'h00000048)
    drive_src(8'h00);
    rd(A_FLAG);
    `CHK(rdat, 32'h00000000)
    `CHK(pin1, 2'h1)
  endtask

  task automatic t_edges_and_or();
    wr(A_CTL, 8'h01);
    wr(A_POL, 8'hF0);
    drive_src(8'hB7);
    rd(A_LIVE);
    `CHK(rdat, 32'h000000B7)
    rd(A_FLAG);
    `CHK(rdat, 32'h000000B0)
    drive_src(8'h00);
    rd(A_FLAG);
    `CHK(rdat, 32'h000000B7)
    settle();
    `CHK(pin0, 2'h3)
  endtask

  task automatic t_clear_and_mask();
    wr(A_FLAG, 8'h0F);
    rd(A_FLAG);
    `CHK(rdat, 32'h00000007)
    // The rising edge on bit 5 is captured at the very edge that takes the clearing write.
    @(posedge pclk);
    src <= 8'h20;
    wr(A_FLAG, 8'h07);
    rd(A_FLAG);
    `CHK(rdat, 32'h00000027)
    wr(A_FLAG, 8'h07);
    rd(A_FLAG);
    `CHK(rdat, 32'h00000007)
    wr(A_MASK, 8'h07);
    settle();
    `CHK(pin0, 2'h1)
  endtask

  task automatic t_and_mode();
    wr(A_CTL, 8'h03);
    wr(A_MASK, 8'hF8);
    settle();
    `CHK(pin1, 2'h3)
    wr(A_MASK, 8'hF0);
    settle();
    `CHK(pin1, 2'h1)
    wr(A_MASK, 8'hF8);
    wr(A_CTL, 8'h02);
    settle();
    `CHK(pin1, 2'h1)
  endtask

  task automatic t_drive_config();
    wr(A_DRV, 8'h3F);
    rd(A_DRV);
    `CHK(rdat, 32'h0000003F)
    wr(A_CTL, 8'h03);
    settle();
    `CHK({sl1, sl0}, 2'h3)
    `CHK({pin1, pin0}, 4'h5)
    `CHK({wire1, wire0}, 2'h0)
    wr(A_CTL, 8'h02);
    settle();
    `CHK({pin1, pin0}, 4'h0)
    `CHK({wire1, wire0}, 2'h3)
  endtask

  task automatic t_slew_and_refusal();
    @(posedge pclk);
    slew <= 4'hA;
    wr(A_SLEW, 8'hFF);
    `CHK(errb, 1'b0)
    rd(A_SLEW);
    `CHK(rdat, 32'h000000A0)
    rd(8'hF0);
    `CHK({errb, rdat}, 33'h100000000)
  endtask

  initial begin
    n_fail = 0;
    samples_checked = 0;
    presetn = 1'b0;
    req = '0;
    src = '0;
    slew = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values();
    t_disabled_capture();
    t_edges_and_or();
    t_clear_and_mask();
    t_and_mode();
    t_drive_config();
    t_slew_and_refusal();
    complete_run();
  end
endmodule
